// File: design/cvp_sensor_port.sv
// Purpose: Sensor end of the camera video port: frame timing and pin drive
// Assumes: CFG_LOAD/SW_RESET come from the control-bus decoder on CLK
// Notes:   RST_N is the hard reset pin; a built-in pattern stands for pixels
//
// Summary of operation
// [RL1] Prescaler divides pixel rate by two to 64
// [RL2] Dummy pixel times after line-valid rises
// [RL3] Dummy lines lengthen vertical blanking
// [RL4] Rate select gives 36/18/6/3 MHz ratios
// [RL5] Scaled size down to 40x30, host tolerant
// [RL6] Hard reset restores all register defaults
// [RL7] Control-bus reset request also restores defaults
// [RL8] Power-down pin halts clock, clears counters
// [RL9] Software standby freezes clock, keeps counters and registers
// [RL10] Ten-bit port with optional bit reversal
// [RL11] Master or slave pixel clock source
// [RL12] Falling sample edge default, rising selectable
// [RL13] Gated pixel clock only during line-valid
// [RL14] Full lines alternate B/G and G/R
// [RL15] Half mode takes column pairs 0,1,4,5...
// [RL16] Exposure input high holds array in reset
// [RL17] Host starts snapshot with trigger input
// [RL18] Flash pin is input until strobe enabled
// [RL19] Video pins are inputs until port enabled
// [RL20] Trigger precharges; trigger fall streams frame
// [RL21] Ungated pixel clock runs through blanking
`timescale 1ns/1ns
`default_nettype none
module cvp_sensor_port import cvp_pkg::*; (
  // Clock and hard reset
  input  wire logic     CLK,
  input  wire logic     RST_N,
  // Control-bus side
  input  wire logic     CFG_LOAD,
  input  wire cvp_cfg_s CFG_IN,
  input  wire logic     SW_RESET,
  input  wire logic     SW_STANDBY,
  // Status
  output cvp_cfg_s      CFG_OUT,
  output logic          ARRAY_RESET,
  output logic          STANDBY,
  // Link
  cvp_if.dev            LNK
);
  typedef struct packed {
    cvp_cfg_s               cfg;
    cvp_snap_e              snap;
    logic [1:0]             pd_s;
    logic [1:0]             hclk_s;
    logic [1:0]             trig_s;
    logic [1:0]             expn_s;
    logic                   hclk_d;
    logic [DIV_W-1:0]       div;
    logic [CNT_W-1:0]       col;
    logic [CNT_W-1:0]       row;
    logic [1:0][WORD_W-1:0] mem;
    logic                   wp;
    logic                   rp;
    logic [1:0]             fill;
    logic                   pclk;
    logic                   pclk_pin;
    logic                   lv;
    logic                   fs;
    logic [VD_W-1:0]        vd;
    logic                   strb;
    logic                   arr;
    logic                   stby;
  } cvp_dev_s;

  localparam cvp_dev_s DEV_RESET = '{cfg: CFG_DEFAULT, snap: SNP_LIVE, default: '0};

  cvp_dev_s r;
  cvp_dev_s n;
  logic     drive_en;

  always_comb begin
    logic              pd;
    logic              run;
    logic              hold;
    logic              tick;
    logic              push;
    logic              pop;
    logic              done;
    logic              lv_g;
    logic              pix_g;
    logic [DIV_W-1:0]  period;
    logic [CNT_W-1:0]  w;
    logic [CNT_W-1:0]  h;
    logic [CNT_W-1:0]  top;
    logic [CNT_W-1:0]  line_len;
    logic [CNT_W-1:0]  frame_len;
    logic [CNT_W-1:0]  img_col;
    logic [CNT_W-1:0]  src_col;
    logic [CNT_W-1:0]  img_row;
    logic [VD_W-1:0]   data;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] head;
    tick    = 1'b0;
    w       = '0;
    h       = '0;
    src_col = '0;
    n = r;
    n.pd_s   = {r.pd_s[0], LNK.power_down_in};
    n.hclk_s = {r.hclk_s[0], LNK.pclk};
    n.trig_s = {r.trig_s[0], LNK.snapshot_trigger};
    n.expn_s = {r.expn_s[0], LNK.exposure_start_n};
    n.hclk_d = r.hclk_s[1];
    if (CFG_LOAD) begin
      n.cfg = CFG_IN;
    end
    pd   = r.pd_s[1];
    run  = !pd && !SW_STANDBY; // [RL9]
    hold = (r.snap == SNP_PRECHG) || (r.snap == SNP_EXPOSE);
    done = 1'b0;
    // Prescaler and rate select share one divider
    period = cvp_period(r.cfg.prescale, r.cfg.rate_sel); // [RL1] [RL4]
    // Pixel tick: own divider as master, host clock launch edge as slave
    if (r.cfg.slave) begin // [RL11]
      tick = run && (r.hclk_s[1] != r.hclk_d) && (r.hclk_s[1] != r.cfg.rise_edge);
      n.div = '0;
      // Parked level so the first master tick is a real edge
      n.pclk = r.cfg.rise_edge;
    end else begin
      tick = run && (r.div == '0);
      if (run) begin
        n.div  = (r.div >= period - DIV_W'(1)) ? '0 : r.div + DIV_W'(1);
        // Data changes on the edge opposite the sampling edge
        n.pclk = (r.div < (period >> 1)) != r.cfg.rise_edge; // [RL12] [RL21]
      end
    end
    // Image size per mode; scaled size is clamped
    unique case (r.cfg.mode)
      MODE_FULL: begin
        w = CNT_W'(FULL_W);
        h = CNT_W'(FULL_H);
      end
      MODE_HALF: begin
        w = CNT_W'(HALF_W);
        h = CNT_W'(HALF_H);
      end
      default: begin
        w = cvp_clamp(r.cfg.out_w, MIN_W, HALF_W); // [RL5]
        h = cvp_clamp(r.cfg.out_h, MIN_H, HALF_H);
      end
    endcase
    top       = CNT_W'(VS_LINES + V_BACK);
    line_len  = CNT_W'(r.cfg.dummy_pix) + w + CNT_W'(H_BLANK); // [RL2]
    frame_len = top + h + CNT_W'(r.cfg.dummy_lines); // [RL3]
    img_row   = r.row - top;
    img_col   = r.col - CNT_W'(r.cfg.dummy_pix);
    lv_g      = (r.row >= top) && (r.row < top + h) && (r.col < CNT_W'(r.cfg.dummy_pix) + w);
    pix_g     = lv_g && (r.col >= CNT_W'(r.cfg.dummy_pix)); // [RL2]
    if (r.cfg.mode == MODE_FULL) begin
      src_col = img_col; // [RL14]
    end else begin
      src_col = {1'b0, img_col[CNT_W-3:1], 1'b0, img_col[0]}; // [RL15]
    end
    data = pix_g ? {cvp_color(img_row[0], src_col[0]), src_col[VD_W-3:0]} : '0; // [RL14]
    word = {r.row < CNT_W'(VS_LINES), lv_g, data};
    // Two-entry buffer; generator stalls when it is full
    push = run && !hold && (r.fill != FIFO_DEPTH);
    pop  = tick && (r.fill != 2'h0);
    head = r.mem[r.rp];
    if (push) begin
      n.mem[r.wp] = word;
      n.wp        = !r.wp;
      if (r.col >= line_len - CNT_W'(1)) begin
        n.col = '0;
        if (r.row >= frame_len - CNT_W'(1)) begin
          n.row = '0;
          done  = 1'b1;
        end else begin
          n.row = r.row + CNT_W'(1);
        end
      end else begin
        n.col = r.col + CNT_W'(1);
      end
    end
    if (pop) begin
      n.rp = !r.rp;
      n.fs = head[VD_W+1];
      n.lv = head[VD_W];
      n.vd = r.cfg.swap ? cvp_swap(head[VD_W-1:0]) : head[VD_W-1:0]; // [RL10]
    end else if (tick) begin
      n.fs = 1'b0;
      n.lv = 1'b0;
      n.vd = '0;
    end
    n.fill = 2'(r.fill + {1'b0, push} - {1'b0, pop});
    // Snapshot sequence
    unique case (r.snap)
      SNP_LIVE: begin
        if (r.cfg.snapshot_en && r.trig_s[1]) n.snap = SNP_PRECHG; // [RL17] [RL20]
      end
      SNP_PRECHG: begin
        if (!r.trig_s[1]) n.snap = SNP_READOUT;
        else if (!r.expn_s[1]) n.snap = SNP_EXPOSE;
      end
      SNP_EXPOSE: begin
        if (!r.trig_s[1]) n.snap = SNP_READOUT; // [RL20]
      end
      SNP_READOUT: begin
        if (done) n.snap = SNP_LIVE;
      end
      default: n.snap = SNP_LIVE;
    endcase
    // Held frame restarts from its first line after the trigger
    if (hold) begin
      n.col = '0;
      n.row = '0;
    end
    n.arr  = r.cfg.snapshot_en && r.expn_s[1]; // [RL16]
    n.strb = r.cfg.strobe_en && (r.snap == SNP_EXPOSE);
    n.stby = pd || SW_STANDBY;
    // Pin power-down or soft reset: clock stops, counters cleared; registers kept on power-down
    if (pd || SW_RESET) begin // [RL8]
      n.div  = '0;
      n.col  = '0;
      n.row  = '0;
      n.fill = 2'h0;
      n.wp   = 1'b0;
      n.rp   = 1'b0;
      n.snap = SNP_LIVE;
      n.pclk = 1'b0;
      n.lv   = 1'b0;
      n.fs   = 1'b0;
      n.vd   = '0;
    end
    if (SW_RESET) begin
      n.cfg = CFG_DEFAULT; // [RL7]
    end
    // Gating holds the clock low outside line-valid
    n.pclk_pin = n.pclk && !(n.cfg.gate_clk && !n.lv); // [RL13] [RL21]
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= DEV_RESET; // [RL6]
    end else begin
      r <= n;
    end
  end

  // Video pins stay inputs until the port is enabled
  assign drive_en            = r.cfg.port_en && !r.pd_s[1]; // [RL19]
  assign LNK.pclk_oe_n       = !(drive_en && !r.cfg.slave); // [RL11]
  assign LNK.pclk_o          = r.pclk_pin;
  assign LNK.line_valid_oe_n = !drive_en;
  assign LNK.line_valid_o    = r.lv;
  assign LNK.frame_sync_oe_n = !drive_en;
  assign LNK.frame_sync_o    = r.fs;
  assign LNK.vd_oe_n         = {VD_W{!drive_en}}; // [RL19]
  assign LNK.vd_o            = r.vd;
  assign LNK.strobe_oe_n     = !r.cfg.strobe_en; // [RL18]
  assign LNK.strobe_o        = r.strb;
  assign CFG_OUT             = r.cfg;
  assign ARRAY_RESET         = r.arr;
  assign STANDBY             = r.stby;
endmodule
`default_nettype wire

// File: design/cvp_pkg.sv
// Purpose: Shared constants, types and helpers of the camera video port
// Assumes: One system clock on both ends; pins modelled as out/oe_n pairs
// Notes:   Host and sensor ends both import this package
package cvp_pkg;
  localparam int VD_W       = 10;
  localparam int WORD_W     = VD_W + 2;
  localparam int CNT_W      = 16;
  localparam int DIV_W      = 10;
  localparam int FULL_W     = 1600;
  localparam int FULL_H     = 1200;
  localparam int HALF_W     = 800;
  localparam int HALF_H     = 600;
  localparam int MIN_W      = 40;
  localparam int MIN_H      = 30;
  localparam int VS_LINES   = 4;
  localparam int V_BACK     = 8;
  localparam int LINE_TOTAL = 1922;
  localparam int H_BLANK    = LINE_TOTAL - FULL_W;
  localparam int PRE_MIN    = 1;
  // Pixel clock in MHz for 15, 7.5, 2.5 and 1.25 fps at full size
  localparam int RATE_MHZ [4] = '{36, 18, 6, 3};
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam logic [1:0] CLR_B      = 2'h0;
  localparam logic [1:0] CLR_G      = 2'h1;
  localparam logic [1:0] CLR_R      = 2'h2;

  typedef enum logic [1:0] {MODE_FULL = 2'h0, MODE_HALF = 2'h1, MODE_SCALED = 2'h2} cvp_mode_e;

  typedef enum logic [3:0] {
    SNP_LIVE    = 4'h1,
    SNP_PRECHG  = 4'h2,
    SNP_EXPOSE  = 4'h4,
    SNP_READOUT = 4'h8
  } cvp_snap_e;

  typedef struct packed {
    logic [5:0]  prescale;
    logic [1:0]  rate_sel;
    cvp_mode_e   mode;
    logic [10:0] out_w;
    logic [10:0] out_h;
    logic [11:0] dummy_pix;
    logic [11:0] dummy_lines;
    logic        swap;
    logic        rise_edge;
    logic        gate_clk;
    logic        slave;
    logic        port_en;
    logic        snapshot_en;
    logic        strobe_en;
  } cvp_cfg_s;

  localparam cvp_cfg_s CFG_DEFAULT = '{prescale: 6'h01, rate_sel: 2'h0, mode: MODE_FULL,
                                       out_w: 11'h028, out_h: 11'h01e, default: '0};

  // Master pixel period in system clocks
  function automatic logic [DIV_W-1:0] cvp_period(input logic [5:0] p, input logic [1:0] sel);
    logic [DIV_W-1:0] base;
    logic [DIV_W-1:0] mult;
    base = (p < 6'(PRE_MIN)) ? DIV_W'(PRE_MIN + 1) : DIV_W'(p) + DIV_W'(1);
    mult = DIV_W'(RATE_MHZ[0] / RATE_MHZ[sel]);
    return DIV_W'(base * mult);
  endfunction

  function automatic logic [CNT_W-1:0] cvp_clamp(input logic [10:0] v, input int lo, input int hi);
    logic [CNT_W-1:0] x;
    x = CNT_W'(v);
    if (x < CNT_W'(lo)) x = CNT_W'(lo);
    if (x > CNT_W'(hi)) x = CNT_W'(hi);
    return x;
  endfunction

  function automatic logic [1:0] cvp_color(input logic row_odd, input logic col_odd);
    if (!row_odd) return col_odd ? CLR_G : CLR_B;
    return col_odd ? CLR_R : CLR_G;
  endfunction

  function automatic logic [VD_W-1:0] cvp_swap(input logic [VD_W-1:0] d);
    logic [VD_W-1:0] o;
    for (int i = 0; i < VD_W; i++) begin
      o[i] = d[VD_W-1-i];
    end
    return o;
  endfunction
endpackage

// File: design/cvp_if.sv
// Purpose: Pin-level link between sensor port and host capture
// Assumes: Undriven wires read low
// Notes:   Resolves each two-way pin from its enables
`timescale 1ns/1ns
`default_nettype none
interface cvp_if import cvp_pkg::*; ();
  logic            pclk_o;
  logic            pclk_oe_n;
  logic            line_valid_o;
  logic            line_valid_oe_n;
  logic            frame_sync_o;
  logic            frame_sync_oe_n;
  logic [VD_W-1:0] vd_o;
  logic [VD_W-1:0] vd_oe_n;
  logic            strobe_o;
  logic            strobe_oe_n;
  logic            host_pclk_o;
  logic            host_pclk_oe_n;
  logic            snapshot_trigger;
  logic            exposure_start_n;
  logic            power_down_in;
  logic            pclk;
  logic            line_valid;
  logic            frame_sync;
  logic            strobe;
  logic [VD_W-1:0] video_data;

  assign pclk       = !pclk_oe_n ? pclk_o : (!host_pclk_oe_n ? host_pclk_o : 1'b0);
  assign line_valid = line_valid_o & ~line_valid_oe_n;
  assign frame_sync = frame_sync_o & ~frame_sync_oe_n;
  assign strobe     = strobe_o & ~strobe_oe_n;
  assign video_data = vd_o & ~vd_oe_n;

  modport dev (output pclk_o, pclk_oe_n, line_valid_o, line_valid_oe_n, frame_sync_o, frame_sync_oe_n,
               output vd_o, vd_oe_n, strobe_o, strobe_oe_n,
               input pclk, snapshot_trigger, exposure_start_n, power_down_in);
  modport host (output host_pclk_o, host_pclk_oe_n, snapshot_trigger, exposure_start_n, power_down_in,
                input pclk, line_valid, frame_sync, video_data);
endinterface
`default_nettype wire

// File: design/cvp_host_capture.sv
// Purpose: Host capture end of the camera video port
// Assumes: Same CLK as sensor end; all link inputs double-synchronised
// Notes:   Slave clock period is 2*(SLAVE_DIV+1); keep SLAVE_DIV >= 4
`timescale 1ns/1ns
`default_nettype none
module cvp_host_capture import cvp_pkg::*; (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // Capture settings
  input  wire logic             CFG_RISE_EDGE,
  input  wire logic             CFG_SLAVE,
  input  wire logic [DIV_W-1:0] SLAVE_DIV,
  input  wire logic [11:0]      DUMMY_SKIP,
  // Sensor control
  input  wire logic             TRIG_REQ,
  input  wire logic             EXPOSE_REQ,
  input  wire logic             PWR_DOWN_REQ,
  // Pixel stream out
  output logic                  PIX_VALID,
  output logic [VD_W-1:0]       PIX_DATA,
  output logic                  PIX_FIRST,
  output logic                  FRAME_START,
  output logic [CNT_W-1:0]      LINE_LEN,
  // Link
  cvp_if.host                   LNK
);
  typedef struct packed {
    logic [1:0]            pclk_s;
    logic [1:0]            lv_s;
    logic [1:0]            fs_s;
    logic [1:0][VD_W-1:0]  vd_s;
    logic                  pclk_d;
    logic                  lv_d;
    logic                  fs_d;
    logic [CNT_W-1:0]      cnt;
    logic [DIV_W-1:0]      hdiv;
    logic                  hclk;
    logic                  trig;
    logic                  expn;
    logic                  pd;
    logic                  pix_valid;
    logic                  pix_first;
    logic                  frame_start;
    logic [VD_W-1:0]       pix;
    logic [CNT_W-1:0]      line_len;
  } cvp_host_s;

  localparam cvp_host_s HOST_RESET = '{expn: 1'b1, default: '0};

  cvp_host_s r;
  cvp_host_s n;

  always_comb begin
    logic             edge_s;
    logic [CNT_W-1:0] skip;
    edge_s = 1'b0;
    skip   = CNT_W'(DUMMY_SKIP);
    n = r;
    n.pclk_s = {r.pclk_s[0], LNK.pclk};
    n.lv_s   = {r.lv_s[0], LNK.line_valid};
    n.fs_s   = {r.fs_s[0], LNK.frame_sync};
    n.vd_s   = {r.vd_s[0], LNK.video_data};
    n.pclk_d = r.pclk_s[1];
    n.lv_d   = r.lv_s[1];
    n.fs_d   = r.fs_s[1];
    // Sample on falling edge unless rising is selected
    edge_s = (r.pclk_s[1] != r.pclk_d) && (r.pclk_s[1] == CFG_RISE_EDGE); // [RL12]
    n.pix_valid   = 1'b0;
    n.pix_first   = 1'b0;
    n.frame_start = r.fs_s[1] && !r.fs_d;
    if (edge_s && r.lv_s[1]) begin
      if (r.cnt >= skip) begin
        n.pix_valid = 1'b1;
        n.pix       = r.vd_s[1];
        n.pix_first = (r.cnt == skip);
      end
      n.cnt = r.cnt + CNT_W'(1);
    end
    // Each line measured alone; scaled lines may differ within a frame
    if (!r.lv_s[1] && r.lv_d) begin
      n.line_len = (r.cnt > skip) ? r.cnt - skip : '0; // [RL5]
      n.cnt      = '0;
    end
    // Slave mode clock made by division
    if (CFG_SLAVE) begin // [RL11]
      if (r.hdiv >= SLAVE_DIV) begin
        n.hdiv = '0;
        n.hclk = !r.hclk;
      end else begin
        n.hdiv = r.hdiv + DIV_W'(1);
      end
    end else begin
      n.hdiv = '0;
      n.hclk = 1'b0;
    end
    n.trig = TRIG_REQ; // [RL17]
    n.expn = !EXPOSE_REQ; // [RL16]
    n.pd   = PWR_DOWN_REQ;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= HOST_RESET;
    end else begin
      r <= n;
    end
  end

  assign LNK.host_pclk_o      = r.hclk;
  assign LNK.host_pclk_oe_n   = !CFG_SLAVE;
  assign LNK.snapshot_trigger = r.trig; // [RL20]
  assign LNK.exposure_start_n = r.expn;
  assign LNK.power_down_in    = r.pd;
  assign PIX_VALID            = r.pix_valid;
  assign PIX_DATA             = r.pix;
  assign PIX_FIRST            = r.pix_first;
  assign FRAME_START          = r.frame_start;
  assign LINE_LEN             = r.line_len;
endmodule
`default_nettype wire

// File: dv/cvp_chk.sv
// Purpose: Link assertions for the camera video port
// Assumes: One CLK domain, RST_N async active low
// Notes:   Sees only link wires, so no check depends on config words
`timescale 1ns/1ns
`default_nettype none
module cvp_chk import cvp_pkg::*; (
  // Clock and reset
  input wire logic            CLK,
  input wire logic            RST_N,
  // Link wires
  input wire logic            pclk_o,
  input wire logic            pclk_oe_n,
  input wire logic            host_pclk_oe_n,
  input wire logic            line_valid_o,
  input wire logic            line_valid_oe_n,
  input wire logic            frame_sync_o,
  input wire logic            frame_sync_oe_n,
  input wire logic [VD_W-1:0] vd_o,
  input wire logic [VD_W-1:0] vd_oe_n,
  input wire logic            strobe_o,
  input wire logic            strobe_oe_n,
  input wire logic            exposure_start_n,
  input wire logic            power_down_in
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Sync flops need three cycles, five leaves margin
  sequence pd_held;
    power_down_in [*5];
  endsequence
  sequence back_porch;
    !line_valid_o [*8];
  endsequence

  a_pins_together: assert property (vd_oe_n == {VD_W{line_valid_oe_n}} && frame_sync_oe_n == line_valid_oe_n)
    else $error("video pin enables disagree");
  a_pd_quiet: assert property (pd_held |=> (vd_oe_n == 10'h3ff && !pclk_o && !line_valid_o))
    else $error("pins active during power-down");
  // Inside a line only, so clears and gating edges are not flagged
  a_data_on_edge: assert property ($changed(vd_o) && line_valid_o && $past(line_valid_o) && !pclk_oe_n
                                   && !$past(pclk_oe_n) |-> $changed(pclk_o))
    else $error("data moved without a pixel clock edge");
  a_sync_no_line: assert property (frame_sync_o |-> !line_valid_o)
    else $error("line valid during frame sync");
  a_back_porch: assert property ($fell(frame_sync_o) |-> back_porch)
    else $error("line valid too soon after frame sync");
  a_no_contend: assert property (!host_pclk_oe_n |-> pclk_oe_n)
    else $error("both ends drive pixel clock");
  a_strobe_expose: assert property ($rose(strobe_o) |-> !$past(exposure_start_n, 2))
    else $error("strobe without exposure start");
  a_strobe_drive: assert property ($rose(strobe_o) |-> !strobe_oe_n)
    else $error("strobe raised while pin is input");
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench for both ends of the camera video port
// Assumes: 250 MHz CLK, scaled 40x30 frames for short runs
// Notes:   Pixel expectations come from the Bayer pattern, not the design
`timescale 1ns/1ns
`default_nettype none
module testbench import cvp_pkg::*;;
  logic            clk;
  logic            rst_n;
  logic            cfg_load;
  cvp_cfg_s        cfg_in;
  cvp_cfg_s        cfg_out;
  cvp_cfg_s        base;
  cvp_cfg_s        c;
  logic            sw_reset;
  logic            sw_standby;
  logic            array_reset;
  logic            standby;
  logic            rise_edge;
  logic            slave;
  logic            trig_req;
  logic            expose_req;
  logic            pwr_down_req;
  logic            pix_valid;
  logic            pix_first;
  logic            frame_start;
  logic [VD_W-1:0] pix_data;
  logic [CNT_W-1:0] line_len;
  int              err_total = 0;
  int              n_tests = 0;
  int              cyc = 0;
  int              t0;
  int              r;
  int              h;
  int              pre[5] = '{1, 2, 0, 1, 63};
  int              sel[5] = '{0, 1, 2, 3, 0};

  cvp_if u_cvp_if ();
  cvp_sensor_port u_cvp_sensor_port (.CLK(clk), .RST_N(rst_n), .CFG_LOAD(cfg_load), .CFG_IN(cfg_in),
    .SW_RESET(sw_reset), .SW_STANDBY(sw_standby), .CFG_OUT(cfg_out), .ARRAY_RESET(array_reset),
    .STANDBY(standby), .LNK(u_cvp_if));
  cvp_host_capture u_cvp_host_capture (.CLK(clk), .RST_N(rst_n), .CFG_RISE_EDGE(rise_edge), .CFG_SLAVE(slave),
    .SLAVE_DIV(10'h004), .DUMMY_SKIP(12'h003), .TRIG_REQ(trig_req), .EXPOSE_REQ(expose_req),
    .PWR_DOWN_REQ(pwr_down_req), .PIX_VALID(pix_valid), .PIX_DATA(pix_data), .PIX_FIRST(pix_first),
    .FRAME_START(frame_start), .LINE_LEN(line_len), .LNK(u_cvp_if));
  cvp_chk u_cvp_chk (.CLK(clk), .RST_N(rst_n), .pclk_o(u_cvp_if.pclk_o), .pclk_oe_n(u_cvp_if.pclk_oe_n),
    .host_pclk_oe_n(u_cvp_if.host_pclk_oe_n), .line_valid_o(u_cvp_if.line_valid_o),
    .line_valid_oe_n(u_cvp_if.line_valid_oe_n), .frame_sync_o(u_cvp_if.frame_sync_o),
    .frame_sync_oe_n(u_cvp_if.frame_sync_oe_n), .vd_o(u_cvp_if.vd_o), .vd_oe_n(u_cvp_if.vd_oe_n),
    .strobe_o(u_cvp_if.strobe_o), .strobe_oe_n(u_cvp_if.strobe_oe_n),
    .exposure_start_n(u_cvp_if.exposure_start_n), .power_down_in(u_cvp_if.power_down_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Wide enough for status, count and whole config word in one compare
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, sized for about 2.8 frames of traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic load(input cvp_cfg_s v);
    @(negedge clk);
    cfg_in = v;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask

  task automatic wait_frame();
    do @(negedge clk); while (frame_start !== 1'b1);
  endtask

  task automatic cap_rows(input int rows, input logic swp);
    logic [VD_W-1:0] e;
    for (int rr = 0; rr < rows; rr++) begin
      for (int cc = 0; cc < MIN_W; cc++) begin
        do @(negedge clk); while (pix_valid !== 1'b1);
        e = {(rr % 2 == 0) ? ((cc % 2 == 1) ? CLR_G : CLR_B) : ((cc % 2 == 1) ? CLR_R : CLR_G), 8'((cc / 2) * 4 + cc % 2)};
        if (swp) e = {<<{e}};
        check({pix_first, pix_data}, {cc == 0, e});
      end
    end
  endtask

  task automatic count_rise(input int n, output int rises, output int hi_idle);
    logic prev;
    rises = 0;
    hi_idle = 0;
    prev = u_cvp_if.pclk;
    repeat (n) begin
      @(negedge clk);
      if (u_cvp_if.pclk && !prev) rises++;
      if (u_cvp_if.pclk && !u_cvp_if.line_valid) hi_idle++;
      prev = u_cvp_if.pclk;
    end
  endtask

  initial begin
    {rst_n, cfg_load, sw_reset, sw_standby, rise_edge, slave, trig_req, expose_req, pwr_down_req} = '0;
    cfg_in = CFG_DEFAULT;
    base = CFG_DEFAULT;
    base.mode = MODE_SCALED;
    base.port_en = 1'b1;
    base.dummy_pix = 12'h003;
    base.dummy_lines = 12'h002;
    tick(2);
    rst_n = 1'b1;
    check(cfg_out, CFG_DEFAULT);
    check({u_cvp_if.vd_oe_n, u_cvp_if.line_valid_oe_n, u_cvp_if.strobe_oe_n}, 12'hfff);
    $display("test reset done");
    // Power-down restarts the counters so the first frame is whole
    pwr_down_req = 1'b1;
    load(base);
    tick(8);
    check({u_cvp_if.vd_oe_n, u_cvp_if.pclk, u_cvp_if.line_valid}, 12'hffc);
    check(cfg_out, base);
    pwr_down_req = 1'b0;
    wait_frame();
    t0 = cyc;
    cap_rows(2, 1'b0);
    tick(40);
    check(line_len, 16'h0028);
    wait_frame();
    check(cyc - t0, (VS_LINES + V_BACK + MIN_H + 2) * (3 + MIN_W + H_BLANK) * 2);
    c = base;
    c.swap = 1'b1;
    c.rise_edge = 1'b1;
    rise_edge = 1'b1;
    load(c);
    cap_rows(1, 1'b1);
    rise_edge = 1'b0;
    $display("test stream done");
    for (int i = 0; i < 5; i++) begin
      c = base;
      c.prescale = 6'(pre[i]);
      c.rate_sel = 2'(sel[i]);
      load(c);
      tick(128);
      count_rise(768, r, h);
      check(r, 768 / (((pre[i] == 0) ? 2 : pre[i] + 1) * (RATE_MHZ[0] / RATE_MHZ[sel[i]])));
    end
    c = base;
    c.gate_clk = 1'b1;
    load(c);
    tick(8);
    count_rise(2000, r, h);
    check({h, r < 1000}, {32'h0000_0000, 1'b1});
    c.gate_clk = 1'b0;
    c.slave = 1'b1;
    load(c);
    tick(4);
    slave = 1'b1;
    tick(40);
    count_rise(200, r, h);
    check({r, u_cvp_if.pclk_oe_n}, {32'h0000_0014, 1'b1});
    slave = 1'b0;
    tick(4);
    load(base);
    $display("test clocking done");
    sw_standby = 1'b1;
    tick(6);
    count_rise(100, r, h);
    check({standby, r, cfg_out}, {1'b1, 32'h0000_0000, base});
    sw_standby = 1'b0;
    c = base;
    c.snapshot_en = 1'b1;
    c.strobe_en = 1'b1;
    load(c);
    tick(8);
    check(array_reset, 1'b1);
    trig_req = 1'b1;
    tick(8);
    expose_req = 1'b1;
    tick(8);
    check({array_reset, u_cvp_if.strobe}, 2'h1);
    trig_req = 1'b0;
    wait_frame();
    expose_req = 1'b0;
    tick(8);
    load(base);
    tick(8);
    check(array_reset, 1'b0);
    $display("test snapshot done");
    @(negedge clk);
    sw_reset = 1'b1;
    @(negedge clk);
    sw_reset = 1'b0;
    tick(2);
    check({cfg_out, u_cvp_if.vd_oe_n}, {CFG_DEFAULT, 10'h3ff});
    $display("test soft reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
